// File: mic_interrupt_control.sv
// Interrupt request latching, masking, priority and core entry sequencing.
// Assumes event inputs are single-cycle pulses and pins are synchronous to clock.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Eighteen sources: six pins, eleven peripherals, break
// - Accept needs enable, request set, disable clear
// - Software may clear request bits, never set
// - Enable bits freely written by software
// - Reset and break cannot be masked
// - Disable flag holds off all maskable interrupts
// - Simultaneous requests served singly by priority
// - Acceptance halts core, pushes PC and status
// - Acceptance sets disable flag, clears taken request
// - Vector fetched concurrently with the stack push
// - Valid bit per source of shared vectors
// - Shared source event always sets discrimination bit
// - Invalid shared source never sets shared request
// - Discrimination bits survive interrupt acceptance
// - Software clears discrimination bits, never sets them
// - Priority one reset to seventeen break
// - Key wakeup on falling combined enabled port0
module mic_interrupt_control
  import mic_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output var  logic [7:0]  regRdata,
  input  wire mic_events_t periphEvents,
  input  wire mic_pins_t   edgePins,
  input  wire logic [7:0]  port0Pins,
  input  wire logic        swBreakExec,
  input  wire logic        iFlag,
  input  wire logic        instrBoundary,
  input  wire logic        pushDone,
  input  wire logic        fetchDone,
  output var  mic_core_t   coreCtl
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Lowest index wins; returns hit flag and index
  function automatic logic [4:0] firstSet(input logic [15:0] cand);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (cand[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // Low vector byte, two bytes per priority step
  function automatic logic [7:0] vecLow(input logic [3:0] idx);
    return 8'(VEC_FIRST_LO - {3'h0, idx, 1'b0});
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_REQ-1:0]  req_q, req_d;
  logic [NUM_REQ-1:0]  en_q, en_d;
  logic [3:0]          valid_q, valid_d;
  logic [3:0]          origin_q, origin_d;
  logic [NUM_PINS-1:0] edgeSel_q, edgeSel_d;
  logic [7:0]          keyMask_q, keyMask_d;
  logic                swBreak_q, swBreak_d;
  logic [NUM_PINS-1:0] pinPrev_q;
  logic                keyPrev_q;
  logic                primed_q;
  logic                pushSeen_q, pushSeen_d;
  logic                fetchSeen_q, fetchSeen_d;
  logic [3:0]          lastIdx_q, lastIdx_d;
  mic_state_t          state_q, state_d;
  mic_core_t           core_q, core_d;
  logic [7:0]          rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic wrReqLo  = regWrite && (regAddr == ADDR_REQ_LO);
  wire logic wrReqHi  = regWrite && (regAddr == ADDR_REQ_HI);
  wire logic wrEnLo   = regWrite && (regAddr == ADDR_EN_LO);
  wire logic wrEnHi   = regWrite && (regAddr == ADDR_EN_HI);
  wire logic wrValid  = regWrite && (regAddr == ADDR_VALID);
  wire logic wrOrigin = regWrite && (regAddr == ADDR_ORIGIN);
  wire logic wrEdge   = regWrite && (regAddr == ADDR_EDGE);
  wire logic wrKey    = regWrite && (regAddr == ADDR_KEYMASK);

  // ----------------------------------------------------------------
  // Source events
  // ----------------------------------------------------------------
  // Pin edges; edge select 1 = rising, 0 = falling
  logic [NUM_PINS-1:0] pinEdge;
  wire logic [NUM_PINS-1:0] pinNow = edgePins;
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : gEdge
      assign pinEdge[g] = primed_q && (edgeSel_q[g] ? (pinNow[g] && !pinPrev_q[g])
                                                    : (!pinNow[g] && pinPrev_q[g]));
    end
  endgenerate

  // Unmasked port0 bits count as high in the conjunction
  wire logic keyLevel = &(port0Pins | ~keyMask_q);
  wire logic keyFall  = primed_q && keyPrev_q && !keyLevel && (|keyMask_q);

  // Shared vectors only requested by valid sources
  wire logic keyColl = (keyFall && valid_q[SV_KEY]) ||
                       (periphEvents.collision && valid_q[SV_COLL]);
  wire logic adT1    = (periphEvents.adDone && valid_q[SV_AD]) ||
                       (periphEvents.timer1 && valid_q[SV_T1]);

  // Fifteen request bits from seventeen non-break sources
  wire logic [NUM_REQ-1:0] reqSet = {adT1, periphEvents.timerB, periphEvents.timerA,
                                     periphEvents.timerX, periphEvents.compare,
                                     pinEdge[4], pinEdge[3], pinEdge[2], keyColl,
                                     pinEdge[1], pinEdge[0], periphEvents.serTx2,
                                     periphEvents.serRx2, periphEvents.serTx1,
                                     periphEvents.serRx1};

  // Origin events regardless of valid bits
  wire logic [3:0] originSet = {periphEvents.timer1, periphEvents.adDone,
                                periphEvents.collision, keyFall};

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Disable flag gates everything but break
  wire logic [NUM_REQ-1:0] eligible = req_q & en_q & {NUM_REQ{!iFlag}};
  wire logic [15:0]        cand     = {swBreak_q, eligible};
  wire logic [4:0]         win      = firstSet(cand);
  wire logic               winHit   = win[4];
  wire logic [3:0]         winIdx   = win[3:0];
  wire logic               accept   = (state_q == ST_IDLE) && instrBoundary && winHit;
  wire logic [NUM_REQ-1:0] accClr   = (accept && winIdx != IDX_SWBREAK) ?
                                      NUM_REQ'(16'h0001 << winIdx) : '0;

  // ----------------------------------------------------------------
  // Software clears, as zero bits in the written word
  // ----------------------------------------------------------------
  wire logic [NUM_REQ-1:0] swClr = {wrReqHi ? ~regWdata[6:0] : 7'h00,
                                    wrReqLo ? ~regWdata : 8'h00};

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Set term last so a same-cycle event survives any clear
  always_comb begin
    req_d     = (req_q & ~swClr & ~accClr) | reqSet;
    en_d      = en_q;
    if (wrEnLo) begin
      en_d[7:0] = regWdata;
    end
    if (wrEnHi) begin
      en_d[14:8] = regWdata[6:0];
    end
    valid_d   = wrValid ? regWdata[3:0] : valid_q;
    origin_d  = (origin_q & (wrOrigin ? regWdata[3:0] : 4'hF)) | originSet;
    edgeSel_d = wrEdge ? regWdata[NUM_PINS-1:0] : edgeSel_q;
    keyMask_d = wrKey ? regWdata : keyMask_q;
    swBreak_d = (swBreak_q && !(accept && winIdx == IDX_SWBREAK)) || swBreakExec;
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rdata_d = 8'h00;
    if (regRead) begin
      case (regAddr)
        ADDR_REQ_LO:  rdata_d = req_q[7:0];
        ADDR_REQ_HI:  rdata_d = {1'b0, req_q[14:8]};
        ADDR_EN_LO:   rdata_d = en_q[7:0];
        ADDR_EN_HI:   rdata_d = {1'b0, en_q[14:8]};
        ADDR_VALID:   rdata_d = {4'h0, valid_q};
        ADDR_ORIGIN:  rdata_d = {4'h0, origin_q};
        ADDR_EDGE:    rdata_d = {3'h0, edgeSel_q};
        ADDR_KEYMASK: rdata_d = keyMask_q;
        ADDR_STATUS:  rdata_d = {(state_q != ST_IDLE), winHit, 2'h0, lastIdx_q};
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------
  // Push and vector fetch run together; both completions are awaited
  always_comb begin
    state_d     = state_q;
    core_d      = core_q;
    core_d.setDisable = 1'b0;
    pushSeen_d  = pushSeen_q;
    fetchSeen_d = fetchSeen_q;
    lastIdx_d   = lastIdx_q;
    case (state_q)
      ST_RSTVEC: begin
        core_d.halt   = 1'b1;
        core_d.fetch  = 1'b1;
        core_d.vector = {VEC_HIGH, VEC_RESET_LO};
        if (fetchDone) begin
          state_d = ST_DONE;
        end
      end
      ST_IDLE: begin
        pushSeen_d  = 1'b0;
        fetchSeen_d = 1'b0;
        if (accept) begin
          state_d           = ST_ENTRY;
          core_d.halt       = 1'b1;
          core_d.push       = 1'b1;
          core_d.fetch      = 1'b1;
          core_d.setDisable = 1'b1;
          core_d.vector     = {VEC_HIGH, vecLow(winIdx)};
          lastIdx_d         = winIdx;
        end
      end
      ST_ENTRY: begin
        pushSeen_d  = pushSeen_q || pushDone;
        fetchSeen_d = fetchSeen_q || fetchDone;
        if (pushSeen_d) begin
          core_d.push = 1'b0;
        end
        if (fetchSeen_d) begin
          core_d.fetch = 1'b0;
        end
        if (pushSeen_d && fetchSeen_d) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        core_d.halt  = 1'b0;
        core_d.push  = 1'b0;
        core_d.fetch = 1'b0;
        state_d      = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  // Software registers and request latches
  always_ff @(posedge clock) begin
    if (reset) begin
      req_q     <= '0;
      en_q      <= '0;
      valid_q   <= 4'h0;
      origin_q  <= 4'h0;
      edgeSel_q <= '0;
      keyMask_q <= REG_RESET;
      swBreak_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      req_q     <= req_d;
      en_q      <= en_d;
      valid_q   <= valid_d;
      origin_q  <= origin_d;
      edgeSel_q <= edgeSel_d;
      keyMask_q <= keyMask_d;
      swBreak_q <= swBreak_d;
      rdata_q   <= rdata_d;
    end
  end

  // Edge history; primed flag hides the first sample after reset
  always_ff @(posedge clock) begin
    if (reset) begin
      pinPrev_q <= '0;
      keyPrev_q <= 1'b1;
      primed_q  <= 1'b0;
    end else begin
      pinPrev_q <= pinNow;
      keyPrev_q <= keyLevel;
      primed_q  <= 1'b1;
    end
  end

  // Sequencer; reset vector fetch starts right after release
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q     <= ST_RSTVEC;
      core_q      <= '0;
      pushSeen_q  <= 1'b0;
      fetchSeen_q <= 1'b0;
      lastIdx_q   <= 4'h0;
    end else begin
      state_q     <= state_d;
      core_q      <= core_d;
      pushSeen_q  <= pushSeen_d;
      fetchSeen_q <= fetchSeen_d;
      lastIdx_q   <= lastIdx_d;
    end
  end

  assign regRdata = rdata_q;
  assign coreCtl  = core_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sEntryStart;
    core_q.halt && core_q.push && core_q.fetch && core_q.setDisable;
  endsequence

  sequence sEntryHold;
    core_q.halt && !core_q.setDisable;
  endsequence

  AST_NO_SW_SET: assert property (@(posedge clock) disable iff (reset)
    ((req_q & ~$past(req_q) & ~$past(reqSet)) == '0))
    else $error("request bit rose without a source event");

  AST_EN_WRITE: assert property (@(posedge clock) disable iff (reset)
    wrEnLo |=> (en_q[7:0] == $past(regWdata)))
    else $error("enable write not stored");

  AST_MASKED_HOLD: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_IDLE && iFlag && !swBreak_q) |=> (state_q == ST_IDLE))
    else $error("maskable interrupt taken while disabled");

  AST_SWBREAK_NONMASK: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_IDLE && instrBoundary && swBreak_q) |=> (state_q == ST_ENTRY))
    else $error("break not taken at boundary");

  AST_ENTRY_STEPS: assert property (@(posedge clock) disable iff (reset)
    accept |=> sEntryStart ##1 sEntryHold)
    else $error("entry sequence malformed");

  AST_VECTOR_FETCH: assert property (@(posedge clock) disable iff (reset)
    accept |=> (core_q.vector[15:8] == VEC_HIGH) && core_q.push && core_q.fetch)
    else $error("vector fetch not concurrent with push");

  AST_REQ_TAKEN_CLR: assert property (@(posedge clock) disable iff (reset)
    (accept && winIdx != IDX_SWBREAK && !reqSet[winIdx]) |=> !req_q[$past(winIdx)])
    else $error("taken request bit not cleared");

  AST_PRIORITY: assert property (@(posedge clock) disable iff (reset)
    accept |-> ((eligible & NUM_REQ'((16'h0001 << winIdx) - 16'h0001)) == '0))
    else $error("lower priority chosen over higher");

  AST_DISC_STICKY: assert property (@(posedge clock) disable iff (reset)
    ((($past(origin_q) & ~origin_q) != 4'h0) |-> $past(wrOrigin)))
    else $error("origin bit fell without software clear");

  AST_DISC_SET: assert property (@(posedge clock) disable iff (reset)
    periphEvents.adDone |=> origin_q[SV_AD])
    else $error("origin bit missed event");

  AST_INVALID_NO_REQ: assert property (@(posedge clock) disable iff (reset)
    (keyFall && !valid_q[SV_KEY] && !(periphEvents.collision && valid_q[SV_COLL])
     && !req_q[IDX_KEYCOLL]) |=> !req_q[IDX_KEYCOLL])
    else $error("invalid source set shared request");

  AST_SET_WINS: assert property (@(posedge clock) disable iff (reset)
    (wrReqLo && periphEvents.serRx1) |=> req_q[0])
    else $error("event lost to software clear");

endmodule
`default_nettype wire

// File: mic_pkg.sv
// Constants, field layouts and carrier types of the interrupt controller.
// Assumes one system clock and that every event input is a one-cycle pulse.
`default_nettype none
package mic_pkg;
  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_REQ_LO  = 4'h0;
  localparam logic [3:0] ADDR_REQ_HI  = 4'h1;
  localparam logic [3:0] ADDR_EN_LO   = 4'h2;
  localparam logic [3:0] ADDR_EN_HI   = 4'h3;
  localparam logic [3:0] ADDR_VALID   = 4'h4;
  localparam logic [3:0] ADDR_ORIGIN  = 4'h5;
  localparam logic [3:0] ADDR_EDGE    = 4'h6;
  localparam logic [3:0] ADDR_KEYMASK = 4'h7;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_REQ     = 15;
  localparam int SV_KEY      = 0;
  localparam int SV_COLL     = 1;
  localparam int SV_AD       = 2;
  localparam int SV_T1       = 3;
  localparam int IDX_KEYCOLL = 6;
  localparam int IDX_ADT1    = 14;
  localparam logic [3:0] IDX_SWBREAK = 4'hF;
  localparam int NUM_PINS    = 5;
  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_HIGH     = 8'hFF;
  localparam logic [7:0] VEC_RESET_LO = 8'hFC;
  localparam logic [7:0] VEC_FIRST_LO = 8'hFA;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer1;
    logic adDone;
    logic timerB;
    logic timerA;
    logic timerX;
    logic compare;
    logic collision;
    logic serTx2;
    logic serRx2;
    logic serTx1;
    logic serRx1;
  } mic_events_t;
  typedef struct packed {
    logic cap1;
    logic cap0;
    logic cntr0;
    logic int1;
    logic int0;
  } mic_pins_t;
  typedef struct packed {
    logic        halt;
    logic        push;
    logic        fetch;
    logic        setDisable;
    logic [15:0] vector;
  } mic_core_t;
  typedef enum logic [3:0] {
    ST_RSTVEC = 4'h1,
    ST_IDLE   = 4'h2,
    ST_ENTRY  = 4'h4,
    ST_DONE   = 4'h8
  } mic_state_t;
endpackage
`default_nettype wire

// File: mic_interrupt_control_unused_guard.sv
// Empty companion unit of the interrupt controller; it holds no logic.
// Assumes nothing of its surroundings.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: mic_core_model.sv
// Processor core stand-in: answers the stack push and the vector fetch, and owns the disable flag.
// Assumes coreCtl is registered on clock and that the bench holds the flag through holdI.
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire mic_core_t coreCtl,
  input  wire logic      holdI,
  input  wire logic      slow,
  output var  logic      iFlag,
  output var  logic      instrBoundary,
  output var  logic      pushDone,
  output var  logic      fetchDone
);
  logic [3:0] pushCnt_q;
  logic [3:0] fetchCnt_q;
  logic       iSet_q;
  logic       halt_q;
  // ----------------------------------------------------------------
  // Flag and boundaries
  // ----------------------------------------------------------------
  // Boundaries only while the program runs
  assign instrBoundary = ~coreCtl.halt;
  assign iFlag         = holdI | iSet_q;
  // Handler taken to return at once, so the flag drops one cycle after halt does
  always_ff @(posedge clock) begin
    if (reset) begin
      iSet_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      halt_q <= coreCtl.halt;
      if (coreCtl.setDisable) begin
        iSet_q <= 1'b1;
      end else if (halt_q && !coreCtl.halt) begin
        iSet_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Push and fetch answers
  // ----------------------------------------------------------------
  // Slow mode answers fetch before push, prompt mode both at once
  always_ff @(posedge clock) begin
    if (reset) begin
      pushCnt_q  <= 4'h0;
      fetchCnt_q <= 4'h0;
      pushDone   <= 1'b0;
      fetchDone  <= 1'b0;
    end else begin
      pushDone   <= coreCtl.push && pushCnt_q == (slow ? 4'h5 : 4'h0);
      fetchDone  <= coreCtl.fetch && fetchCnt_q == (slow ? 4'h2 : 4'h0);
      pushCnt_q  <= !coreCtl.push ? 4'h0 : (pushCnt_q == 4'hF ? pushCnt_q : pushCnt_q + 4'h1);
      fetchCnt_q <= !coreCtl.fetch ? 4'h0 : (fetchCnt_q == 4'hF ? fetchCnt_q : fetchCnt_q + 4'h1);
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the interrupt controller with a core model on its far side.
// Assumes one 50 MHz clock and registers reached over the plain strobe port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mic_pkg::*;
  logic        clock, reset, regWrite, regRead, swBreakExec, holdI, slow;
  logic        iFlag, instrBoundary, pushDone, fetchDone;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, port0Pins;
  mic_events_t periphEvents;
  mic_pins_t   edgePins;
  mic_core_t   coreCtl;
  int          mismatches, checks, cycles;

  mic_interrupt_control mic_interrupt_control_inst (.clock, .reset, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .periphEvents, .edgePins, .port0Pins, .swBreakExec, .iFlag, .instrBoundary,
    .pushDone, .fetchDone, .coreCtl);
  mic_core_model mic_core_model_inst (.clock, .reset, .coreCtl, .holdI, .slow, .iFlag,
    .instrBoundary, .pushDone, .fetchDone);
  // ----------------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Whole run needs about four hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Compares and bus cycles
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t vector %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t flag %b want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk8(regRdata, e);
    @(posedge clock);
    #1;
    chk8(regRdata, 8'h00);
  endtask
  task automatic ev(input logic [10:0] e);
    @(posedge clock);
    periphEvents <= mic_events_t'(e);
    @(posedge clock);
    periphEvents <= '0;
  endtask
  // One entry: halt and fetch, with push and setDisable equal to f, in the first halt cycle, then halt released
  task automatic entry(input logic [15:0] v, input logic f);
    int n;
    n = 0;
    #1;
    while (coreCtl.halt !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk1(coreCtl.halt & coreCtl.fetch, 1'b1);
    chk1(coreCtl.push, f);
    chk1(coreCtl.setDisable, f);
    chk16(coreCtl.vector, v);
    while (coreCtl.halt !== 1'b0 && n < 80) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk1(coreCtl.halt, 1'b0);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk1(coreCtl.halt, 1'b0);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    entry(16'hFFFC, 1'b0);
    for (int a = 0; a < 10; a++) begin
      rdc(4'(a), 8'h00);
    end
  endtask
  // Each peripheral event lands on its mapped request bit, A/D and timer 1 both on bit 14; ones never set
  task automatic t_events();
    int          map [11] = '{0, 1, 2, 3, 6, 10, 11, 12, 13, 14, 14};
    logic [14:0] e;
    wr(ADDR_VALID, 8'h0F);
    wr(ADDR_REQ_LO, 8'hFF);
    wr(ADDR_REQ_HI, 8'hFF);
    rdc(ADDR_REQ_LO, 8'h00);
    for (int i = 0; i < 11; i++) begin
      e = 15'h1 << map[i];
      ev(11'h1 << i);
      rdc(ADDR_REQ_LO, e[7:0]);
      rdc(ADDR_REQ_HI, {1'b0, e[14:8]});
      chk1(coreCtl.halt, 1'b0);
      wr(ADDR_REQ_LO, 8'h00);
      wr(ADDR_REQ_HI, 8'h00);
    end
    rdc(ADDR_REQ_HI, 8'h00);
    wr(ADDR_ORIGIN, 8'h00);
  endtask
  // Event and software clear in the same cycle
  task automatic t_race();
    @(posedge clock);
    regAddr      <= ADDR_REQ_LO;
    regWdata     <= 8'h00;
    regWrite     <= 1'b1;
    periphEvents <= mic_events_t'(11'h001);
    @(posedge clock);
    regWrite     <= 1'b0;
    periphEvents <= '0;
    rdc(ADDR_REQ_LO, 8'h01);
    wr(ADDR_REQ_LO, 8'h00);
  endtask
  task automatic t_shared();
    wr(ADDR_VALID, 8'h00);
    ev(11'h410);
    rdc(ADDR_REQ_LO, 8'h00);
    rdc(ADDR_REQ_HI, 8'h00);
    rdc(ADDR_ORIGIN, 8'h0A);
    wr(ADDR_ORIGIN, 8'hFF);
    rdc(ADDR_ORIGIN, 8'h0A);
    wr(ADDR_ORIGIN, 8'hFD);
    rdc(ADDR_ORIGIN, 8'h08);
    wr(ADDR_ORIGIN, 8'h00);
    wr(ADDR_VALID, 8'h02);
    wr(ADDR_EN_LO, 8'h40);
    ev(11'h010);
    entry(16'hFFEE, 1'b1);
    rdc(ADDR_ORIGIN, 8'h02);
    rdc(ADDR_REQ_LO, 8'h00);
    wr(ADDR_EN_LO, 8'h00);
    wr(ADDR_ORIGIN, 8'h00);
  endtask
  task automatic t_key();
    wr(ADDR_VALID, 8'h01);
    wr(ADDR_KEYMASK, 8'h01);
    wr(ADDR_REQ_LO, 8'h00);
    @(posedge clock);
    port0Pins <= 8'hFE;
    repeat (2) @(posedge clock);
    rdc(ADDR_REQ_LO, 8'h40);
    rdc(ADDR_ORIGIN, 8'h01);
    wr(ADDR_REQ_LO, 8'h00);
    port0Pins <= 8'hFF;
    repeat (2) @(posedge clock);
    port0Pins <= 8'hFD;
    repeat (2) @(posedge clock);
    rdc(ADDR_REQ_LO, 8'h00);
    wr(ADDR_ORIGIN, 8'h00);
    wr(ADDR_VALID, 8'h00);
    port0Pins <= 8'hFE;
    repeat (2) @(posedge clock);
    rdc(ADDR_REQ_LO, 8'h00);
    rdc(ADDR_ORIGIN, 8'h01);
    wr(ADDR_KEYMASK, 8'h00);
  endtask
  // Masked while the flag is held, break still taken, then priority order
  task automatic t_prio();
    int idx [5] = '{4, 5, 7, 8, 9};
    @(posedge clock);
    holdI <= 1'b1;
    wr(ADDR_EDGE, 8'h1F);
    wr(ADDR_REQ_LO, 8'h00);
    wr(ADDR_REQ_HI, 8'h00);
    edgePins <= mic_pins_t'(5'h1F);
    repeat (2) @(posedge clock);
    rdc(ADDR_REQ_LO, 8'hB0);
    rdc(ADDR_REQ_HI, 8'h03);
    wr(ADDR_EN_LO, 8'hFF);
    wr(ADDR_EN_HI, 8'h7F);
    rdc(ADDR_EN_LO, 8'hFF);
    rdc(ADDR_EN_HI, 8'h7F);
    quiet(8);
    @(posedge clock);
    swBreakExec <= 1'b1;
    @(posedge clock);
    swBreakExec <= 1'b0;
    entry(16'hFFDC, 1'b1);
    @(posedge clock);
    holdI <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      entry(16'hFFFA - 16'(2 * idx[i]), 1'b1);
      slow <= ~slow;
    end
    rdc(ADDR_REQ_LO, 8'h00);
    rdc(ADDR_REQ_HI, 8'h00);
    rdc(ADDR_STATUS, 8'h09);
    wr(ADDR_EN_LO, 8'h00);
    wr(ADDR_EN_HI, 8'h00);
    wr(ADDR_EDGE, 8'h00);
    edgePins <= mic_pins_t'(5'h0E);
    repeat (2) @(posedge clock);
    rdc(ADDR_REQ_LO, 8'h10);
    rdc(ADDR_REQ_HI, 8'h02);
    wr(ADDR_REQ_LO, 8'h00);
    wr(ADDR_REQ_HI, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches   = 0;
    checks       = 0;
    cycles       = 0;
    reset        = 1'b1;
    regWrite     = 1'b0;
    regRead      = 1'b0;
    regAddr      = 4'h0;
    regWdata     = 8'h00;
    swBreakExec  = 1'b0;
    holdI        = 1'b0;
    slow         = 1'b0;
    port0Pins    = 8'hFF;
    edgePins     = '0;
    periphEvents = '0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_events();
    t_race();
    t_shared();
    t_key();
    t_prio();
    summarize();
  end
endmodule
`default_nettype wire
